//--- rtl/machine_interrupt_pending_enable.sv
/*
  machine-level interrupt pending and enable registers of one hart,
  the supervisor views, and the trap decision with cause selection.
  assumes request lines are synchronous to SYS_CLK, the timer and
  software lines come from memory-mapped registers elsewhere, and
  privilege, global enables and delegation mask are driven by the hart.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - cause i sits at bit i
// - trap when pending, enabled, undelegated, allowed
// - re-evaluate trap condition every cycle
// - machine interrupts before lower-mode interrupts
// - zero clears writable pending bits
// - enables writable if pendable, else zero
// - machine external pending follows controller line
// - timer pending follows comparator, read-only
// - machine software pending from memory-mapped line
// - no supervisor: supervisor bits read zero
// - supervisor external reads software OR line
// - updates touch only stored supervisor external
// - supervisor timer pending writable
// - supervisor software writable, controller may set
// - overflow pending set by flags, writable
// - fixed priority among machine interrupts
// - supervisor views show delegated bits only
// - non-maskable interrupt never in pending
// - delegated interrupts masked in machine mode
module machine_interrupt_pending_enable #(
  parameter bit HAS_SUPERVISOR = 1'b1,
  parameter bit HAS_COUNTER_OVF = 1'b1,
  parameter bit HAS_SOFT_IRQ = 1'b1,
  parameter bit PLATFORM_HIGH = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CSR_VALID,
  input wire logic [1:0] CSR_SEL,
  input wire logic [1:0] CSR_OP,
  input wire logic [63:0] CSR_WDATA,
  output logic [63:0] CSR_RDATA,
  output logic CSR_READY,
  input wire logic [1:0] PRIV,
  input wire logic MACHINE_IE,
  input wire logic SUPERVISOR_IE,
  input wire logic [63:0] DELEG_MASK,
  input wire logic TRAP_RETURN,
  input wire logic MACHINE_EXT_REQ,
  input wire logic SUPERVISOR_EXT_REQ,
  input wire logic TIMER_REQ,
  input wire logic SOFT_REQ,
  input wire logic SUPERVISOR_SOFT_SET,
  input wire logic [28:0] OVERFLOW_FLAGS,
  input wire logic [47:0] PLATFORM_REQ,
  output logic TRAP_REQ,
  output logic TRAP_TO_SUPERVISOR,
  output logic [5:0] TRAP_CAUSE
);
  // ----------------------------------------
  // stored state
  // ----------------------------------------
  logic supervisor_external_pending_sw_q;
  logic supervisor_timer_pending_q;
  logic supervisor_software_pending_q;
  logic lcof_q;
  logic [63:0] enable_q;
  logic [63:0] enable_d;

  // ----------------------------------------
  // writable masks
  // ----------------------------------------
  logic [63:0] pend_wr_mask;
  logic [63:0] en_wr_mask;
  logic [63:0] deleg;

  assign deleg = HAS_SUPERVISOR ? DELEG_MASK : 64'h0;

  // only these pending bits take writes
  always_comb begin
    pend_wr_mask = 64'h0;
    pend_wr_mask[irq_pkg::SEI_BIT] = HAS_SUPERVISOR;
    pend_wr_mask[irq_pkg::STI_BIT] = HAS_SUPERVISOR;
    pend_wr_mask[irq_pkg::SSI_BIT] = HAS_SUPERVISOR;
    pend_wr_mask[irq_pkg::LCOF_BIT] = HAS_COUNTER_OVF;
  end

  // enable writable where pending can rise
  always_comb begin
    en_wr_mask = 64'h0;
    en_wr_mask[63:irq_pkg::PLAT_LO] = {irq_pkg::PLAT_W{1'b1}};
    en_wr_mask[irq_pkg::MEI_BIT] = 1'b1;
    en_wr_mask[irq_pkg::MTI_BIT] = 1'b1;
    en_wr_mask[irq_pkg::MSI_BIT] = HAS_SOFT_IRQ;
    en_wr_mask[irq_pkg::SEI_BIT] = HAS_SUPERVISOR;
    en_wr_mask[irq_pkg::STI_BIT] = HAS_SUPERVISOR;
    en_wr_mask[irq_pkg::SSI_BIT] = HAS_SUPERVISOR;
    en_wr_mask[irq_pkg::LCOF_BIT] = HAS_COUNTER_OVF;
  end

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  logic wr_any;
  logic wr_pend;
  logic wr_en;
  logic [63:0] pend_mask_eff;
  logic [63:0] en_mask_eff;

  assign wr_any = CSR_VALID && (CSR_OP != irq_pkg::OP_READ);

  // supervisor writes reach delegated bits only
  always_comb begin
    wr_pend = 1'b0;
    wr_en = 1'b0;
    pend_mask_eff = pend_wr_mask;
    en_mask_eff = en_wr_mask;
    if (wr_any && CSR_SEL == irq_pkg::SEL_PENDING) begin
      wr_pend = 1'b1;
    end else if (wr_any && CSR_SEL == irq_pkg::SEL_ENABLE) begin
      wr_en = 1'b1;
    end else if (wr_any && CSR_SEL == irq_pkg::SEL_S_PENDING) begin
      wr_pend = 1'b1;
      pend_mask_eff = pend_wr_mask & deleg;
    end else if (wr_any && CSR_SEL == irq_pkg::SEL_S_ENABLE) begin
      wr_en = 1'b1;
      en_mask_eff = en_wr_mask & deleg;
    end
  end

  // ----------------------------------------
  // pending update
  // ----------------------------------------
  logic [63:0] pend_sw_old;
  logic [63:0] pend_sw_new;

  // stored supervisor external bit, never the line
  always_comb begin
    pend_sw_old = 64'h0;
    pend_sw_old[irq_pkg::SEI_BIT] = supervisor_external_pending_sw_q;
    pend_sw_old[irq_pkg::STI_BIT] = supervisor_timer_pending_q;
    pend_sw_old[irq_pkg::SSI_BIT] = supervisor_software_pending_q;
    pend_sw_old[irq_pkg::LCOF_BIT] = lcof_q;
  end

  csr_field_update pend_upd (
    .old_val(pend_sw_old),
    .wdata(CSR_WDATA),
    .op(CSR_OP),
    .wr_mask(wr_pend ? pend_mask_eff : 64'h0),
    .new_val(pend_sw_new)
  );

  csr_field_update en_upd (
    .old_val(enable_q),
    .wdata(CSR_WDATA),
    .op(CSR_OP),
    .wr_mask(wr_en ? en_mask_eff : 64'h0),
    .new_val(enable_d)
  );

  logic supervisor_external_pending_sw_d;
  logic supervisor_timer_pending_d;
  logic supervisor_software_pending_d;
  logic lcof_d;
  logic ovf_any;

  assign ovf_any = |OVERFLOW_FLAGS;
  assign supervisor_external_pending_sw_d = pend_sw_new[irq_pkg::SEI_BIT];
  assign supervisor_timer_pending_d = pend_sw_new[irq_pkg::STI_BIT];
  // controller set wins over software clear
  assign supervisor_software_pending_d = pend_sw_new[irq_pkg::SSI_BIT] |
                  (HAS_SUPERVISOR & SUPERVISOR_SOFT_SET);
  // overflow flag set wins over clear
  assign lcof_d = pend_sw_new[irq_pkg::LCOF_BIT] |
                  (HAS_COUNTER_OVF & ovf_any);

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      supervisor_external_pending_sw_q <= 1'b0;
      supervisor_timer_pending_q <= 1'b0;
      supervisor_software_pending_q <= 1'b0;
      lcof_q <= 1'b0;
    end else begin
      supervisor_external_pending_sw_q <= supervisor_external_pending_sw_d;
      supervisor_timer_pending_q <= supervisor_timer_pending_d;
      supervisor_software_pending_q <= supervisor_software_pending_d;
      lcof_q <= lcof_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      enable_q <= irq_pkg::ENABLE_RST;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ----------------------------------------
  // pending view
  // ----------------------------------------
  // built from any stored set plus live lines; the
  // non-maskable interrupt has no position here at all
  logic [63:0] pend_now;
  logic [63:0] pend_next;

  function automatic logic [63:0] pend_view(
    input logic supervisor_external_pending_sw,
    input logic supervisor_timer_pending,
    input logic supervisor_software_pending,
    input logic lcof
  );
    logic [63:0] v;
    v = 64'h0;
    // platform lines at bit 16 upward
    v[63:irq_pkg::PLAT_LO] = PLATFORM_REQ;
    // external pending is the controller line
    v[irq_pkg::MEI_BIT] = MACHINE_EXT_REQ;
    // comparator line, cleared by compare write
    v[irq_pkg::MTI_BIT] = TIMER_REQ;
    v[irq_pkg::MSI_BIT] = HAS_SOFT_IRQ & SOFT_REQ;
    v[irq_pkg::SEI_BIT] = HAS_SUPERVISOR & (supervisor_external_pending_sw | SUPERVISOR_EXT_REQ);
    v[irq_pkg::STI_BIT] = HAS_SUPERVISOR & supervisor_timer_pending;
    v[irq_pkg::SSI_BIT] = HAS_SUPERVISOR & supervisor_software_pending;
    v[irq_pkg::LCOF_BIT] = HAS_COUNTER_OVF & lcof;
    return v;
  endfunction

  // no bit for the non-maskable interrupt
  // always_comb, not assign: the live request lines read
  // inside the function must wake this logic as well
  always_comb begin
    pend_now = pend_view(supervisor_external_pending_sw_q, supervisor_timer_pending_q, supervisor_software_pending_q, lcof_q);
  end

  always_comb begin
    pend_next = pend_view(supervisor_external_pending_sw_d, supervisor_timer_pending_d, supervisor_software_pending_d, lcof_d);
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [63:0] rdata_d;

  always_comb begin
    if (CSR_SEL == irq_pkg::SEL_PENDING) begin
      rdata_d = pend_now;
    end else if (CSR_SEL == irq_pkg::SEL_ENABLE) begin
      rdata_d = enable_q;
    end else if (CSR_SEL == irq_pkg::SEL_S_PENDING) begin
      rdata_d = pend_now & deleg;
    end else begin
      rdata_d = enable_q & deleg;
    end
  end

  // read shows the value before this access's update
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CSR_RDATA <= 64'h0;
      CSR_READY <= 1'b0;
    end else begin
      CSR_READY <= CSR_VALID;
      if (CSR_VALID) begin
        CSR_RDATA <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // trap decision
  // ----------------------------------------
  logic m_allowed;
  logic s_allowed;
  logic [63:0] active;
  logic [63:0] m_elig;
  logic [63:0] s_elig;
  logic m_found;
  logic s_found;
  logic [5:0] m_cause;
  logic [5:0] s_cause;

  // next-state values, so writes act at once
  assign active = pend_next & enable_d;

  // each global enable only matters in its own mode
  assign m_allowed = (PRIV != irq_pkg::PRIV_M) || MACHINE_IE;
  assign s_allowed = (PRIV == irq_pkg::PRIV_U) ||
                     ((PRIV == irq_pkg::PRIV_S) && SUPERVISOR_IE);

  // delegated bits never taken in machine mode
  assign m_elig = m_allowed ? (active & ~deleg) : 64'h0;
  assign s_elig = s_allowed ? (active & deleg) : 64'h0;

  irq_select m_sel (
    .elig(m_elig),
    .plat_high(PLATFORM_HIGH),
    .found(m_found),
    .cause(m_cause)
  );

  irq_select s_sel (
    .elig(s_elig),
    .plat_high(PLATFORM_HIGH),
    .found(s_found),
    .cause(s_cause)
  );

  // trap return changes privilege and enables; the
  // per-cycle evaluation already follows it, held here
  // only to keep the request low in that cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TRAP_REQ <= 1'b0;
      TRAP_TO_SUPERVISOR <= 1'b0;
      TRAP_CAUSE <= irq_pkg::CAUSE_RST;
    end else if (TRAP_RETURN) begin
      TRAP_REQ <= 1'b0;
      TRAP_TO_SUPERVISOR <= 1'b0;
    end else if (m_found) begin
      TRAP_REQ <= 1'b1;
      TRAP_TO_SUPERVISOR <= 1'b0;
      TRAP_CAUSE <= m_cause;
    end else if (s_found) begin
      TRAP_REQ <= 1'b1;
      TRAP_TO_SUPERVISOR <= 1'b1;
      TRAP_CAUSE <= s_cause;
    end else begin
      TRAP_REQ <= 1'b0;
      TRAP_TO_SUPERVISOR <= 1'b0;
    end
  end
endmodule // machine_interrupt_pending_enable
`default_nettype wire

//--- rtl/irq_pkg.sv
/*
  constants for the machine interrupt pending/enable block:
  bit positions, access encodings, privilege codes.
  assumes a 64-bit control-register width.
*/
package irq_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int XLEN = 64;
  localparam int CAUSE_W = 6;
  localparam int STD_BITS = 16;
  localparam int PLAT_LO = 16;
  localparam int PLAT_W = 48;
  localparam int OVF_W = 29;

  // ----------------------------------------
  // standard cause bit positions
  // ----------------------------------------
  localparam int SSI_BIT = 1;
  localparam int MSI_BIT = 3;
  localparam int STI_BIT = 5;
  localparam int MTI_BIT = 7;
  localparam int SEI_BIT = 9;
  localparam int MEI_BIT = 11;
  localparam int LCOF_BIT = 13;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [63:0] ENABLE_RST = 64'h0;
  localparam logic [5:0] CAUSE_RST = 6'h0;

  // ----------------------------------------
  // privilege codes
  // ----------------------------------------
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // ----------------------------------------
  // access port encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_SET = 2'b10,
    OP_CLEAR = 2'b11
  } csr_op_t;

  typedef enum logic [1:0] {
    SEL_PENDING = 2'b00,
    SEL_ENABLE = 2'b01,
    SEL_S_PENDING = 2'b10,
    SEL_S_ENABLE = 2'b11
  } csr_sel_t;
endpackage

//--- rtl/csr_field_update.sv
/*
  next value of a software-held register field for write, set and clear.
  assumes old holds only the stored bits, never live request lines.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_field_update (
  input wire logic [63:0] old_val,
  input wire logic [63:0] wdata,
  input wire logic [1:0] op,
  input wire logic [63:0] wr_mask,
  output logic [63:0] new_val
);
  logic [63:0] f;

  always_comb begin
    case (op)
      irq_pkg::OP_WRITE: f = wdata;
      irq_pkg::OP_SET: f = old_val | wdata;
      irq_pkg::OP_CLEAR: f = old_val & ~wdata;
      default: f = old_val;
    endcase
    // bits outside the mask keep their stored value
    new_val = (old_val & ~wr_mask) | (f & wr_mask);
  end
endmodule // csr_field_update
`default_nettype wire

//--- rtl/irq_select.sv
/*
  fixed priority picker over a 64-bit eligible vector.
  assumes eligible bits are already masked and gated.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_select (
  input wire logic [63:0] elig,
  input wire logic plat_high,
  output logic found,
  output logic [5:0] cause
);
  logic std_found;
  logic [5:0] std_cause;
  logic plat_found;
  logic [5:0] plat_cause;

  // ----------------------------------------
  // standard causes
  // ----------------------------------------
  // fixed order: MEI, MSI, MTI, SEI, SSI, STI, LCOF
  always_comb begin
    std_found = 1'b1;
    if (elig[irq_pkg::MEI_BIT]) begin
      std_cause = 6'(irq_pkg::MEI_BIT);
    end else if (elig[irq_pkg::MSI_BIT]) begin
      std_cause = 6'(irq_pkg::MSI_BIT);
    end else if (elig[irq_pkg::MTI_BIT]) begin
      std_cause = 6'(irq_pkg::MTI_BIT);
    end else if (elig[irq_pkg::SEI_BIT]) begin
      std_cause = 6'(irq_pkg::SEI_BIT);
    end else if (elig[irq_pkg::SSI_BIT]) begin
      std_cause = 6'(irq_pkg::SSI_BIT);
    end else if (elig[irq_pkg::STI_BIT]) begin
      std_cause = 6'(irq_pkg::STI_BIT);
    end else if (elig[irq_pkg::LCOF_BIT]) begin
      std_cause = 6'(irq_pkg::LCOF_BIT);
    end else begin
      std_found = 1'b0;
      std_cause = irq_pkg::CAUSE_RST;
    end
  end

  // ----------------------------------------
  // platform causes
  // ----------------------------------------
  // lowest platform index wins among themselves
  always_comb begin
    plat_found = 1'b0;
    plat_cause = irq_pkg::CAUSE_RST;
    for (int i = 63; i >= irq_pkg::PLAT_LO; i--) begin
      if (elig[i]) begin
        plat_found = 1'b1;
        plat_cause = 6'(i);
      end
    end
  end

  always_comb begin
    found = std_found | plat_found;
    if (plat_found && (plat_high || !std_found)) begin
      cause = plat_cause;
    end else begin
      cause = std_cause;
    end
  end
endmodule // irq_select
`default_nettype wire

//--- sim/irq_properties.sv
/*
  port-level checks on the interrupt pending/enable block.
  assumes the block's default parameters and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_properties (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CSR_VALID,
  input wire logic [1:0] CSR_SEL,
  input wire logic [63:0] CSR_RDATA,
  input wire logic CSR_READY,
  input wire logic [1:0] PRIV,
  input wire logic MACHINE_IE,
  input wire logic [63:0] DELEG_MASK,
  input wire logic TRAP_RETURN,
  input wire logic TRAP_REQ,
  input wire logic TRAP_TO_SUPERVISOR,
  input wire logic [5:0] TRAP_CAUSE
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  chk_ready_answer: assert property (CSR_VALID |=> CSR_READY)
    else $error("access not answered one cycle later");
  chk_ready_idle: assert property (!CSR_VALID |=> !CSR_READY)
    else $error("answer without an access");
  chk_m_masked: assert property (PRIV == irq_pkg::PRIV_M && !MACHINE_IE |=> !TRAP_REQ)
    else $error("trap taken in machine mode with global enable off");
  chk_return_drop: assert property (TRAP_RETURN |=> !TRAP_REQ)
    else $error("trap request not dropped after trap return");
  chk_m_undeleg: assert property (TRAP_REQ && !TRAP_TO_SUPERVISOR
    |-> (($past(DELEG_MASK) >> TRAP_CAUSE) & 64'h1) == 64'h0)
    else $error("delegated cause trapped to machine mode");
  chk_s_deleg: assert property (TRAP_REQ && TRAP_TO_SUPERVISOR
    |-> $past(PRIV) != irq_pkg::PRIV_M && (($past(DELEG_MASK) >> TRAP_CAUSE) & 64'h1) != 64'h0)
    else $error("lower-mode trap not delegated or taken in machine mode");
  chk_sview_deleg: assert property (CSR_VALID && CSR_SEL[1]
    |=> (CSR_RDATA & ~$past(DELEG_MASK)) == 64'h0)
    else $error("supervisor view shows an undelegated bit");
  chk_reserved_zero: assert property (CSR_VALID && !CSR_SEL[1]
    |=> (CSR_RDATA[15:0] & 16'hd555) == 16'h0)
    else $error("unimplemented standard bit reads non-zero");
  chk_cause_std: assert property (TRAP_REQ && TRAP_CAUSE < 6'h10
    |-> TRAP_CAUSE[0] && TRAP_CAUSE <= 6'h0d)
    else $error("trap cause is not an implemented cause");
endmodule // irq_properties

bind machine_interrupt_pending_enable irq_properties chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .CSR_VALID(CSR_VALID), .CSR_SEL(CSR_SEL), .CSR_RDATA(CSR_RDATA), .CSR_READY(CSR_READY),
  .PRIV(PRIV), .MACHINE_IE(MACHINE_IE), .DELEG_MASK(DELEG_MASK), .TRAP_RETURN(TRAP_RETURN),
  .TRAP_REQ(TRAP_REQ), .TRAP_TO_SUPERVISOR(TRAP_TO_SUPERVISOR), .TRAP_CAUSE(TRAP_CAUSE));
`default_nettype wire

//--- sim/irq_sources.sv
/*
  platform request sources: external controller, timer, software reg.
  assumes the bench pulses the write strobes for one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_sources (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_line,
  input wire logic sw_wr,
  input wire logic sw_val,
  input wire logic tmr_fire,
  input wire logic cmp_wr,
  output logic m_ext_req,
  output logic timer_q,
  output logic soft_q
);
  assign m_ext_req = ext_line;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 1'b0;
    end else if (cmp_wr) begin
      timer_q <= 1'b0;
    end else if (tmr_fire) begin
      timer_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
    end else if (sw_wr) begin
      soft_q <= sw_val;
    end
  end
endmodule // irq_sources
`default_nettype wire

//--- sim/machine_interrupt_pending_enable_tb.sv
/*
  self-checking bench for the interrupt pending/enable block.
  assumes default parameters and the irq_sources model.
*/
`timescale 1ns/10ps
`default_nettype none
module machine_interrupt_pending_enable_tb;
  logic SYS_CLK, RESETN, CSR_VALID, CSR_READY, MACHINE_IE, SUPERVISOR_IE, TRAP_RETURN;
  logic [1:0] CSR_SEL, CSR_OP, PRIV;
  logic [63:0] CSR_WDATA, CSR_RDATA, DELEG_MASK;
  logic MACHINE_EXT_REQ, SUPERVISOR_EXT_REQ, TIMER_REQ, SOFT_REQ, SUPERVISOR_SOFT_SET;
  logic [28:0] OVERFLOW_FLAGS;
  logic [47:0] PLATFORM_REQ;
  logic TRAP_REQ, TRAP_TO_SUPERVISOR;
  logic [5:0] TRAP_CAUSE;
  logic ext_line, sw_wr, sw_val, tmr_fire, cmp_wr;
  logic low_req, low_sup;
  logic [5:0] low_cause;
  int n_errors = 0;
  int comparisons = 0;
  logic [5:0] prio [7] = '{6'h0b, 6'h03, 6'h07, 6'h09, 6'h01, 6'h05, 6'h0d};

  machine_interrupt_pending_enable dut (.SYS_CLK, .RESETN, .CSR_VALID, .CSR_SEL, .CSR_OP,
    .CSR_WDATA, .CSR_RDATA, .CSR_READY, .PRIV, .MACHINE_IE, .SUPERVISOR_IE, .DELEG_MASK,
    .TRAP_RETURN, .MACHINE_EXT_REQ, .SUPERVISOR_EXT_REQ, .TIMER_REQ, .SOFT_REQ,
    .SUPERVISOR_SOFT_SET, .OVERFLOW_FLAGS, .PLATFORM_REQ, .TRAP_REQ, .TRAP_TO_SUPERVISOR,
    .TRAP_CAUSE);
  irq_sources partner (.clk(SYS_CLK), .rst_n(RESETN), .ext_line(ext_line), .sw_wr(sw_wr),
    .sw_val(sw_val), .tmr_fire(tmr_fire), .cmp_wr(cmp_wr), .m_ext_req(MACHINE_EXT_REQ),
    .timer_q(TIMER_REQ), .soft_q(SOFT_REQ));
  // second copy with platform lines ranked below the standard causes
  machine_interrupt_pending_enable #(.PLATFORM_HIGH(1'b0)) dut_low (.SYS_CLK, .RESETN,
    .CSR_VALID, .CSR_SEL, .CSR_OP, .CSR_WDATA, .CSR_RDATA(), .CSR_READY(), .PRIV,
    .MACHINE_IE, .SUPERVISOR_IE, .DELEG_MASK, .TRAP_RETURN, .MACHINE_EXT_REQ,
    .SUPERVISOR_EXT_REQ, .TIMER_REQ, .SOFT_REQ, .SUPERVISOR_SOFT_SET, .OVERFLOW_FLAGS,
    .PLATFORM_REQ, .TRAP_REQ(low_req), .TRAP_TO_SUPERVISOR(low_sup), .TRAP_CAUSE(low_cause));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask

  // one access, then an idle cycle so strobes never toggle twice in a step
  task automatic csr(input logic [1:0] sel, input logic [1:0] op, input logic [63:0] wd,
                     input logic [63:0] mask, input logic [63:0] exp);
    CSR_VALID = 1'b1;
    CSR_SEL = sel;
    CSR_OP = op;
    CSR_WDATA = wd;
    tick(1);
    CSR_VALID = 1'b0;
    check({63'h0, CSR_READY}, 64'h1);
    check(CSR_RDATA & mask, exp);
    tick(1);
  endtask

  task automatic trap(input logic sup, input logic [5:0] cause);
    check({56'h0, TRAP_REQ, TRAP_TO_SUPERVISOR, TRAP_CAUSE}, {56'h0, 1'b1, sup, cause});
  endtask

  // lowest platform line wins when platform ranks highest
  function automatic logic [5:0] plat_cause(input logic [47:0] r);
    for (int i = 0; i < 48; i++) begin
      if (r[i]) begin
        return 6'(i + 16);
      end
    end
    return 6'h0;
  endfunction

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  initial begin
    logic [63:0] d;
    logic [63:0] e;
    logic [63:0] f;
    {RESETN, CSR_VALID, CSR_SEL, CSR_OP, CSR_WDATA, PRIV, MACHINE_IE, SUPERVISOR_IE} = '0;
    {DELEG_MASK, TRAP_RETURN, SUPERVISOR_EXT_REQ, SUPERVISOR_SOFT_SET} = '0;
    {OVERFLOW_FLAGS, PLATFORM_REQ, ext_line, sw_wr, sw_val, tmr_fire, cmp_wr} = '0;
    d = 64'($urandom(16263));
    e = 64'h0;
    f = irq_pkg::ENABLE_RST;
    tick(2);
    RESETN = 1'b1;
    tick(1);
    csr(irq_pkg::SEL_ENABLE, irq_pkg::OP_READ, 64'h0, '1, irq_pkg::ENABLE_RST);
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_READ, 64'h0, '1, 64'h0);
    $display("test reset values done");

    // a write answers with the stored value from before it
    for (int k = 0; k < 8; k++) begin
      d = {$urandom, $urandom};
      csr(irq_pkg::SEL_PENDING, irq_pkg::OP_WRITE, d, '1, e);
      e = d & 64'h2222;
      csr(irq_pkg::SEL_PENDING, irq_pkg::OP_READ, 64'h0, '1, e);
      check(CSR_RDATA & 64'h20, d & 64'h20);
      csr(irq_pkg::SEL_ENABLE, irq_pkg::OP_WRITE, d, '1, f);
      f = d & 64'hffff_ffff_ffff_2aaa;
      csr(irq_pkg::SEL_ENABLE, irq_pkg::OP_READ, 64'h0, '1, f);
    end
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_CLEAR, '1, '1, e);
    SUPERVISOR_SOFT_SET = 1'b1;
    OVERFLOW_FLAGS = 29'($urandom) | 29'h1;
    tick(1);
    {SUPERVISOR_SOFT_SET, OVERFLOW_FLAGS} = '0;
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_READ, 64'h0, '1, 64'h2002);
    check(CSR_RDATA & 64'h2000, 64'h2000);
    $display("test pending writes done");

    // stored bit must ignore the live line even through a set access
    SUPERVISOR_EXT_REQ = 1'b1;
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_WRITE, 64'h0, 64'h200, 64'h200);
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_SET, 64'h0, 64'h200, 64'h200);
    SUPERVISOR_EXT_REQ = 1'b0;
    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_READ, 64'h0, 64'h200, 64'h0);
    $display("test supervisor external done");

    csr(irq_pkg::SEL_ENABLE, irq_pkg::OP_WRITE, '1, '1, f);
    e = 64'h0;
    tmr_fire = 1'b1;
    for (int k = 0; k < 8; k++) begin
      ext_line = (k == 0);
      sw_val = (k < 2);
      sw_wr = 1'b1;
      cmp_wr = (k == 3);
      tick(1);
      {sw_wr, cmp_wr, tmr_fire} = '0;
      d = 64'h0;
      for (int j = k; j < 7; j++) begin
        d[prio[j]] = 1'b1;
      end
      csr(irq_pkg::SEL_PENDING, irq_pkg::OP_WRITE, d, 64'h2222, e);
      e = d & 64'h2222;
      if (k < 7) begin
        trap(1'b0, prio[k]);
      end else begin
        check({63'h0, TRAP_REQ}, 64'h0);
      end
    end
    $display("test priority order done");

    ext_line = 1'b1;
    for (int k = 0; k < 6; k++) begin
      PLATFORM_REQ = 48'({$urandom, $urandom}) | 48'h8000_0000_0000;
      tick(1);
      trap(1'b0, plat_cause(PLATFORM_REQ));
      check({57'h0, low_req, low_cause}, {57'h0, 1'b1, 6'h0b});
    end
    {PLATFORM_REQ, ext_line} = '0;
    $display("test platform rank done");

    csr(irq_pkg::SEL_PENDING, irq_pkg::OP_WRITE, 64'h20, '1, 64'h0);
    PRIV = irq_pkg::PRIV_M;
    tick(1);
    check({63'h0, TRAP_REQ}, 64'h0);
    MACHINE_IE = 1'b1;
    tick(1);
    trap(1'b0, 6'h05);
    DELEG_MASK = 64'h20;
    tick(1);
    check({63'h0, TRAP_REQ}, 64'h0);
    PRIV = irq_pkg::PRIV_S;
    SUPERVISOR_IE = 1'b1;
    ext_line = 1'b1;
    tick(1);
    trap(1'b0, 6'h0b);
    ext_line = 1'b0;
    tick(1);
    trap(1'b1, 6'h05);
    csr(irq_pkg::SEL_S_PENDING, irq_pkg::OP_READ, 64'h0, '1, 64'h20);
    csr(irq_pkg::SEL_S_ENABLE, irq_pkg::OP_READ, 64'h0, '1, 64'h20);
    TRAP_RETURN = 1'b1;
    tick(1);
    TRAP_RETURN = 1'b0;
    check({63'h0, TRAP_REQ}, 64'h0);
    tick(1);
    trap(1'b1, 6'h05);
    $display("test masking and delegation done");
    stop_test();
  end
endmodule // machine_interrupt_pending_enable_tb
`default_nettype wire
